// *** src/ccp_regs.vh ***
// register offsets, field positions, reset values for control channel path config
`ifndef CCP_REGS_VH
`define CCP_REGS_VH
// Functional notes
// - bit 7 set: forward every I2C transaction to the remote serializer.
// - bit 6 set: forward a transaction only when its address decode matches.
// - bit 5 set: acknowledge every I2C write locally, whatever lock or remote ack.
// - bit 4 resets to 1; 1 keeps return link on, 0 needs a forward bit.
// - bit 4 changes only by local I2C writes, never by remote channel writes.
// - bit 3 resets to 1 and enables return link check generation.
// - rate codes: 000 2.5M, 010 10M, 101 25M, 110 50M; others reserved.
// - rate field reset value comes from the strap sampled at power-down release.
// - keep-local bit 7 set blocks forward-channel loading of path control registers.
// - pin count field: 00 none, 01 one, 10 two, 11 four pins.
// - pin count normally loads from remote; local writes apply only when keep-local is already set.
// - decode match: address equals a nonzero 7-bit alias of serializer or target.
`define CCP_ADDR_CC_CONFIG 8'h58
`define CCP_ADDR_PATH_CTL1 8'h59
`define CCP_BIT_FWD_ALL 7
`define CCP_BIT_FWD_MATCH 6
`define CCP_BIT_AUTO_ACK 5
`define CCP_BIT_FORCED_ON 4
`define CCP_BIT_CHECK_GEN 3
`define CCP_BIT_KEEP_LOCAL 7
`define CCP_CC_RST_UPPER 5'h03
`define CCP_PATH_RST 8'h00
`define CCP_RATE_2M5 3'h0
`define CCP_RATE_10M 3'h2
`define CCP_RATE_25M 3'h5
`define CCP_RATE_50M 3'h6
`define CCP_NUM_ALIAS 5
`endif

// *** src/ccp_addr_match.v ***
// alias address decoder for forwarded I2C transactions
`timescale 1ns/1ps
`include "ccp_regs.vh"
module ccp_addr_match #(
    parameter NUM_ALIAS = `CCP_NUM_ALIAS
) (
    input wire [6:0] i2c_addr,
    input wire [7*NUM_ALIAS-1:0] alias_list,
    output wire hit
);
    wire [NUM_ALIAS-1:0] hit_vec;
    genvar g;
    generate
        for (g = 0; g < NUM_ALIAS; g = g + 1) begin : g_cmp
            // zero alias disables that entry
            assign hit_vec[g] = (alias_list[7*g +: 7] != 7'h00) && (alias_list[7*g +: 7] == i2c_addr);
        end
    endgenerate
    assign hit = |hit_vec;
endmodule // ccp_addr_match

// *** src/ccp_config.v ***
// control channel and forward path configuration registers
`timescale 1ns/1ps
`include "ccp_regs.vh"
module ccp_config #(
    parameter NUM_ALIAS = `CCP_NUM_ALIAS
) (
    input wire sys_clk,
    input wire rst_n,
    input wire power_down_bar_pin,
    input wire [2:0] rate_strap_pins,
    input wire reg_wr,
    input wire reg_rd,
    input wire reg_remote,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    input wire fc_load,
    input wire [1:0] fc_pin_count,
    input wire i2c_start,
    input wire i2c_is_write,
    input wire [6:0] i2c_addr,
    input wire [7*NUM_ALIAS-1:0] alias_list,
    input wire remote_ack,
    input wire fwd_lock,
    output wire i2c_forward,
    output wire i2c_local_ack,
    output wire return_link_en,
    output wire return_link_check_gen_en,
    output wire [2:0] return_link_rate_sel,
    output wire rate_reserved,
    output wire [2:0] downstream_pins_active
);
    reg [1:0] pdb_sync_q;
    reg [2:0] strap_s1_q;
    reg [2:0] strap_s2_q;
    reg pdb_seen_q;
    reg [4:0] cc_upper_q;
    reg [2:0] rate_q;
    reg keep_local_q;
    reg [4:0] path_rsvd_q;
    reg [1:0] pin_count_q;
    wire held_down;
    wire addr_hit;
    wire wr_cc;
    wire wr_path;

    // external pins pass two flops before use
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            pdb_sync_q <= 2'h0;
            strap_s1_q <= 3'h0;
            strap_s2_q <= 3'h0;
        end else begin
            pdb_sync_q <= {pdb_sync_q[0], power_down_bar_pin};
            strap_s1_q <= rate_strap_pins;
            strap_s2_q <= strap_s1_q;
        end
    end

    assign held_down = !rst_n || !pdb_sync_q[1];
    assign wr_cc = reg_wr && (reg_addr == `CCP_ADDR_CC_CONFIG);
    assign wr_path = reg_wr && (reg_addr == `CCP_ADDR_PATH_CTL1);

    always @(posedge sys_clk) begin
        if (held_down) begin
            // defaults restored while powered down
            cc_upper_q <= `CCP_CC_RST_UPPER;
            keep_local_q <= 1'b0;
            path_rsvd_q <= 5'h00;
            pin_count_q <= 2'h0;
            pdb_seen_q <= 1'b0;
            rate_q <= 3'h0;
        end else begin
            pdb_seen_q <= 1'b1;
            // strap captured on the first cycle after release, not under reset
            if (!pdb_seen_q) begin
                rate_q <= strap_s2_q;
            end else if (wr_cc) begin
                rate_q <= reg_wdata[2:0];
            end
            if (wr_cc) begin
                cc_upper_q[4:3] <= reg_wdata[7:6];
                cc_upper_q[2] <= reg_wdata[5];
                // remote channel cannot flip forced-on
                if (!reg_remote) begin
                    cc_upper_q[1] <= reg_wdata[4];
                end
                cc_upper_q[0] <= reg_wdata[3];
            end
            if (wr_path) begin
                keep_local_q <= reg_wdata[`CCP_BIT_KEEP_LOCAL];
                path_rsvd_q <= reg_wdata[6:2];
            end
            // forward channel load wins unless local values are kept
            if (fc_load && !keep_local_q) begin
                pin_count_q <= fc_pin_count;
            end else if (wr_path && keep_local_q) begin
                pin_count_q <= reg_wdata[1:0];
            end
        end
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `CCP_ADDR_CC_CONFIG: begin
                    reg_rdata <= {cc_upper_q, rate_q};
                end
                `CCP_ADDR_PATH_CTL1: begin
                    reg_rdata <= {keep_local_q, path_rsvd_q, pin_count_q};
                end
                default: begin
                    reg_rdata <= 8'h00;
                end
            endcase
        end
    end

    ccp_addr_match #(
        .NUM_ALIAS(NUM_ALIAS)
    ) u_match (
        .i2c_addr(i2c_addr),
        .alias_list(alias_list),
        .hit(addr_hit)
    );

    assign i2c_forward = i2c_start && (cc_upper_q[4] || (cc_upper_q[3] && addr_hit));
    // auto-ack ignores lock and remote answer
    assign i2c_local_ack = i2c_is_write && (cc_upper_q[2] || (fwd_lock && remote_ack));
    assign return_link_en = cc_upper_q[1] || cc_upper_q[4] || cc_upper_q[3];
    assign return_link_check_gen_en = cc_upper_q[0];
    assign return_link_rate_sel = rate_q;
    assign rate_reserved = !((rate_q == `CCP_RATE_2M5) || (rate_q == `CCP_RATE_10M) ||
        (rate_q == `CCP_RATE_25M) || (rate_q == `CCP_RATE_50M));
    assign downstream_pins_active = (pin_count_q == 2'h3) ? 3'h4 : {1'b0, pin_count_q};
endmodule // ccp_config

// *** tb/ccp_chk.sv ***
// port assertions for the config block
`timescale 1ns/1ps
module ccp_chk #(
    parameter NUM_ALIAS = 5
) (
    input wire sys_clk,
    input wire rst_n,
    input wire reg_wr,
    input wire reg_remote,
    input wire fc_load,
    input wire i2c_start,
    input wire i2c_is_write,
    input wire i2c_forward,
    input wire i2c_local_ack,
    input wire return_link_en,
    input wire return_link_check_gen_en,
    input wire rate_reserved,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [1:0] fc_pin_count,
    input wire [6:0] i2c_addr,
    input wire [7*NUM_ALIAS-1:0] alias_list,
    input wire [2:0] return_link_rate_sel,
    input wire [2:0] downstream_pins_active
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wire w58 = reg_wr && reg_addr == 8'h58;
    wire w59 = reg_wr && reg_addr == 8'h59 && !reg_remote;
    wire [7:0] d = reg_wdata;
    fwd_all_a: assert property (w58 && d[7] |=> i2c_forward == i2c_start) else $error("fwd all");
    alias_hit_a: assert property (w58 && d[7:6] == 2'h1 ##1 i2c_start && i2c_addr != 7'h00 &&
        i2c_addr == alias_list[6:0] |-> i2c_forward) else $error("alias");
    auto_ack_a: assert property (w58 && d[5] |=> !i2c_is_write || i2c_local_ack) else $error("ack");
    link_off_a: assert property (w58 && !reg_remote && d[7:4] == 4'h0 |=> !return_link_en) else $error("link");
    crc_gen_a: assert property (w58 |=> return_link_check_gen_en == $past(d[3])) else $error("crc");
    rate_flag_a: assert property (rate_reserved == !(return_link_rate_sel inside {3'h0, 3'h2, 3'h5, 3'h6}))
        else $error("rate");
    pin_load_a: assert property (w59 && !d[7] ##2 fc_load |=> downstream_pins_active ==
        ($past(fc_pin_count) == 2'h3 ? 3'h4 : {1'h0, $past(fc_pin_count)})) else $error("load");
    keep_local_a: assert property (w59 && d[7] ##2 fc_load |=> $stable(downstream_pins_active))
        else $error("keep");
    cover property (i2c_forward);
    cover property (fc_load);
    cover property (rate_reserved);
endmodule // ccp_chk
bind ccp_config ccp_chk #(.NUM_ALIAS(NUM_ALIAS)) chk (.*);

// *** tb/ccp_remote_model.sv ***
// remote serializer model sending pin count loads
`timescale 1ns/1ps
module ccp_remote_model (
    input wire sys_clk,
    output reg fc_load = 1'h0,
    output reg [1:0] fc_pin_count = 2'h0,
    output reg remote_ack = 1'h0);
    task send(input [1:0] c);
        begin
            @(posedge sys_clk) #1 fc_load = 1'h1;
            fc_pin_count = c;
            @(posedge sys_clk) #1 fc_load = 1'h0;
            fc_pin_count = ~c; // no stale count between loads
        end
    endtask
endmodule // ccp_remote_model

// *** tb/ccp_config_tb.sv ***
// self-checking bench for the config block
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin mismatches++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module ccp_config_tb;
    reg sys_clk = 0, rst_n = 0, power_down_bar_pin = 0, reg_wr = 0, reg_rd = 0, reg_remote = 0;
    reg i2c_start = 0, i2c_is_write = 0, fwd_lock = 0;
    reg [2:0] rate_strap_pins = 3'h5;
    reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    reg [6:0] i2c_addr = 7'h21;
    reg [34:0] alias_list = 35'h21;
    wire [7:0] reg_rdata;
    wire fc_load, remote_ack, i2c_forward, i2c_local_ack, return_link_en, return_link_check_gen_en, rate_reserved;
    wire [1:0] fc_pin_count;
    wire [2:0] return_link_rate_sel, downstream_pins_active;
    integer mismatches = 0, total_checks = 0, cyc = 0, i;
    ccp_config dut (.*);
    ccp_remote_model rm (.*);
    always #10 sys_clk = ~sys_clk;
    task tick;
        @(posedge sys_clk) #1;
    endtask
    // idle cycle first so back-to-back calls never touch the strobe twice at once
    task wr(input [7:0] a, v, input r);
        begin
            tick;
            reg_wr = 1;
            reg_addr = a;
            reg_wdata = v;
            reg_remote = r;
            tick;
            reg_wr = 0;
        end
    endtask
    task rd(input [7:0] a, e);
        begin
            tick;
            reg_rd = 1;
            reg_addr = a;
            tick;
            reg_rd = 0;
            `CHK("rdata", e, reg_rdata)
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", total_checks, mismatches);
            if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            mismatches++;
            complete_run;
        end
    end
    initial begin
        repeat (5) tick;
        rst_n = 1;
        power_down_bar_pin = 1;
        repeat (6) tick;
        rd(8'h58, 8'h1D);
        `CHK("rate_sel", 3'h5, return_link_rate_sel)
        rd(8'h5A, 8'h00);
        `CHK("crc", 1'h1, return_link_check_gen_en)
        `CHK("link_on", 1'h1, return_link_en)
        for (i = 0; i < 8; i++) begin
            wr(8'h58, {5'h03, i[2:0]}, 0);
            `CHK("rsv", (i == 1 || i == 3 || i == 4 || i == 7), rate_reserved)
        end
        i2c_start = 1;
        i2c_is_write = 1;
        wr(8'h58, 8'h00, 0);
        `CHK("link", 1'h0, return_link_en)
        `CHK("fwd", 1'h0, i2c_forward)
        `CHK("ack", 1'h0, i2c_local_ack)
        // remote host turns on auto-ack before touching the rate
        wr(8'h58, 8'h20, 1);
        wr(8'h58, 8'h32, 1);
        `CHK("link_kept", 1'h0, return_link_en)
        rd(8'h58, 8'h22);
        wr(8'h58, 8'h40, 0);
        `CHK("hit", 1'h1, i2c_forward)
        tick;
        i2c_addr = 7'h00;
        tick;
        `CHK("zero", 1'h0, i2c_forward)
        wr(8'h58, 8'h80, 0);
        `CHK("all", 1'h1, i2c_forward)
        wr(8'h58, 8'h20, 0);
        `CHK("auto", 1'h1, i2c_local_ack)
        rm.send(2'h3);
        `CHK("pins", 3'h4, downstream_pins_active)
        wr(8'h59, 8'h02, 0);
        rd(8'h59, 8'h03);
        wr(8'h59, 8'h80, 0);
        wr(8'h59, 8'hFD, 0);
        rm.send(2'h2);
        `CHK("kept", 3'h1, downstream_pins_active)
        rd(8'h59, 8'hFD);
        wr(8'h59, 8'h00, 0);
        `CHK("none", 3'h0, downstream_pins_active)
        rm.send(2'h2);
        `CHK("two", 3'h2, downstream_pins_active)
        power_down_bar_pin = 0;
        rate_strap_pins = 3'h6;
        repeat (4) tick;
        power_down_bar_pin = 1;
        repeat (6) tick;
        rd(8'h58, 8'h1E);
        rd(8'h59, 8'h00);
        complete_run;
    end
endmodule // ccp_config_tb
